// *** dxr_map.svh ***
// Function
// R01 - cpu_interface bit 0 selects 8-bit (default) or 16-bit cpu memory access
// R02 - cpu_interface bit 1 routes shared pin: bias enable (default) or interrupt request
// R03 - cpu_interface bits 4-3 select attribute controller port mapping; 01 holds flip-flop reset
// R04 - cpu_interface bit 5 selects full 16-bit or lower 10-bit io decode
// R05 - cpu_interface bit 7 reads attribute flip-flop state, read only
// R06 - memory_control bit 2 enables display address counter bit 16, clear after reset
// R07 - memory_control bit 4 selects dram strobe scheme for 256kx16 part
// R08 - memory_control bit 5 enables cpu write buffering, disabled after reset
// R09 - palette_control bit 5 feeds low 6 pixel bits to gray modulation logic
// R10 - palette_control bits 7-6 select colour to gray reduction, 11 reserved
// R11 - cpu_paging bit 0 extended mapping, bit 1 dual map access
// R12 - cpu_paging bit 2 divides cpu address by 4, bit 4 linear addressing
// R13 - start_address_top bit 0 is start address msb; bits 7-1 written zero
// R14 - auxiliary_offset bit 0 extends normal offset, bit 1 alternate offset
// R15 - text_mode_control bit 2 steady cursor, bit 3 exclusive-or cursor
// R16 - software_flags_two holds eight read-write bits with no hardware effect
// R17 - low_map_base supplies cpu address bits 17-10 of single or low map
// R18 - high_map_base supplies upper map base bits 17-10 in dual map mode
// R19 - emulation_mode bits 1-0 select emulation; bits 3-2 read back mono config
// R20 - emulation_mode bits 6-4 select input status register 1 sources
// R21 - emulation_mode bit 7 sets interrupt pin drive behaviour
// R22 - group_write_protect bits 6-0 block group writes; bit 6 ored with retrace end bit 7
// R23 - host writes 7-bit index to index port, then uses data port
// R24 - protected writes are dropped silently; reads still return contents
`ifndef DXR_MAP_SVH
`define DXR_MAP_SVH
`define DXR_IX_CPU_IF    7'h02
`define DXR_IX_MEM_CTL   7'h04
`define DXR_IX_PAL_CTL   7'h06
`define DXR_IX_PAGING    7'h0b
`define DXR_IX_START_TOP 7'h0c
`define DXR_IX_AUX_OFS   7'h0d
`define DXR_IX_TEXT_CTL  7'h0e
`define DXR_IX_SWFLAGS2  7'h0f
`define DXR_IX_LOW_MAP   7'h10
`define DXR_IX_HIGH_MAP  7'h11
`define DXR_IX_EMUL      7'h14
`define DXR_IX_PROTECT   7'h15
`define DXR_RST_ZERO     8'h00
`define DXR_RST_MEM_CTL  8'h01
`define DXR_RST_PAL_CTL  8'h10
`define DXR_CPU_IF_WMASK 8'h3b
`define DXR_START_WMASK  8'h01
`define DXR_AUX_WMASK    8'h03
`define DXR_TEXT_WMASK   8'h0c
`define DXR_PAGING_WMASK 8'h17
`define DXR_EMUL_WMASK   8'hf3
`define DXR_PROT_WMASK   8'h7f
`define DXR_ATTR_16BIT   2'b01
`define DXR_IDX_W        7
`endif

// *** dxr_pkg.sv ***
`default_nettype none
package dxr_pkg;
  typedef enum logic [1:0] {DXR_ACC_IDLE, DXR_ACC_WRITE, DXR_ACC_READ} dxr_acc_e;
  typedef struct packed {
    logic [6:0] index;
    logic [7:0] cpu_if;
    logic [7:0] mem_ctl;
    logic [7:0] pal_ctl;
    logic [7:0] paging;
    logic [7:0] start_top;
    logic [7:0] aux_ofs;
    logic [7:0] text_ctl;
    logic [7:0] swflags2;
    logic [7:0] low_map;
    logic [7:0] high_map;
    logic [7:0] emul;
    logic [7:0] protect;
    logic [7:0] rdata;
    logic       rvalid;
    dxr_acc_e   acc;
  } dxr_regs_s;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s0;
  } dxr_sync_s;
endpackage : dxr_pkg
`default_nettype wire

// *** dxr_sync.sv ***
`default_nettype none
module dxr_sync (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic [1:0] i_async,
  output logic      [1:0] o_sync
);
  dxr_pkg::dxr_sync_s st_ff;
  dxr_pkg::dxr_sync_s nxt_st;
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s0 = i_async;
    nxt_st.s1 = st_ff.s0;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign o_sync = st_ff.s1;
endmodule : dxr_sync
`default_nettype wire

// *** dxr_irq_pin.sv ***
`default_nettype none
module dxr_irq_pin (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_enable,
  input  wire logic i_active,
  input  wire logic i_channel_bus,
  input  wire logic i_mode,
  output logic      o_irq_o,
  output logic      o_irq_oe
);
  logic [1:0] pin_ff;
  logic [1:0] nxt_pin;
  // pin_ff[1] = drive level, pin_ff[0] = output enable
  always_comb begin
    nxt_pin = 2'b00;
    if (i_enable) begin
      if (i_mode) begin
        nxt_pin = {i_active, 1'b1}; // R21
      end else if (i_channel_bus && i_active) begin
        nxt_pin = 2'b01; // R21
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_ff <= 2'b00;
    end else begin
      pin_ff <= nxt_pin;
    end
  end
  assign o_irq_o  = pin_ff[1];
  assign o_irq_oe = pin_ff[0];
  chk_irq_float_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_enable |=> !o_irq_oe) else $error("irq pin driven while disabled"); // R21
  chk_irq_high_act: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_enable && i_mode) |=> (o_irq_oe && o_irq_o == $past(i_active)))
    else $error("irq pin level wrong in driven mode"); // R21
endmodule : dxr_irq_pin
`default_nettype wire

// *** dxr_ext_regs.sv ***
`include "dxr_map.svh"
`default_nettype none
module dxr_ext_regs (
  input  wire logic       I_CLK,
  input  wire logic       I_ARST_N,
  input  wire logic       I_IDX_WR,
  input  wire logic       I_IDX_RD,
  input  wire logic       I_DATA_WR,
  input  wire logic       I_DATA_RD,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_ATTR_FF,
  input  wire logic [1:0] I_MONO_CFG,
  input  wire logic       I_RETRACE_END_PROT,
  input  wire logic       I_PANEL_BIAS_EN,
  input  wire logic       I_IRQ_ENABLE,
  input  wire logic       I_IRQ_ACTIVE,
  input  wire logic       I_CHANNEL_BUS,
  input  wire logic       I_EXT_PAL_RD,
  input  wire logic       I_EXT_PAL_WR,
  output logic      [7:0] O_RDATA,
  output logic            O_RVALID,
  output logic            O_CPU_MEM_16BIT,
  output logic            O_SHARED_PIN,
  output logic      [1:0] O_ATTR_MAP,
  output logic            O_ATTR_FF_HOLD,
  output logic            O_IO_DECODE_10BIT,
  output logic            O_ADDR_BIT16_EN,
  output logic            O_STROBE_SCHEME,
  output logic            O_WRITE_BUF_EN,
  output logic            O_PAL_BYPASS,
  output logic      [1:0] O_GRAY_REDUCE,
  output logic            O_EXT_MAP,
  output logic            O_DUAL_MAP,
  output logic            O_ADDR_DIV4,
  output logic            O_LINEAR_ADDR,
  output logic            O_START_MSB,
  output logic      [1:0] O_OFFSET_LSB,
  output logic            O_CURSOR_STEADY,
  output logic            O_CURSOR_XOR,
  output logic      [7:0] O_LOW_MAP_BASE,
  output logic      [7:0] O_HIGH_MAP_BASE,
  output logic      [1:0] O_EMUL_MODE,
  output logic      [2:0] O_STATUS_SRC,
  output logic      [6:0] O_GROUP_PROTECT,
  output logic            O_EXT_PAL_RD_N,
  output logic            O_EXT_PAL_WR_N,
  output logic            O_IRQ_O,
  output logic            O_IRQ_OE
);
  dxr_pkg::dxr_regs_s r_ff;
  dxr_pkg::dxr_regs_s nxt_r;
  logic [1:0]         mono_sync;
  logic [1:0]         strobe_ff;
  logic [1:0]         nxt_strobe;
  logic               shared_ff;
  logic               nxt_shared;
  logic               irq_drv_o;
  logic               irq_drv_oe;
  logic [6:0]         gprot_ff;
  logic [6:0]         nxt_gprot;
  logic               hold_ff;
  logic               nxt_hold;

  function automatic logic [7:0] wr_masked(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] mask);
    wr_masked = (old_v & ~mask) | (new_v & mask);
  endfunction : wr_masked

  dxr_sync u_mono_sync (
    .i_clk   (I_CLK),
    .i_arst_n(I_ARST_N),
    .i_async (I_MONO_CFG),
    .o_sync  (mono_sync)
  );

  dxr_irq_pin u_irq_pin (
    .i_clk        (I_CLK),
    .i_arst_n     (I_ARST_N),
    .i_enable     (I_IRQ_ENABLE && r_ff.cpu_if[1]),
    .i_active     (I_IRQ_ACTIVE),
    .i_channel_bus(I_CHANNEL_BUS),
    .i_mode       (r_ff.emul[7]),
    .o_irq_o      (irq_drv_o),
    .o_irq_oe     (irq_drv_oe)
  );

  // register read view, shared by the read path
  function automatic logic [7:0] rd_view(input dxr_pkg::dxr_regs_s r, input logic af,
                                         input logic [1:0] mono);
    case (r.index)
      `DXR_IX_CPU_IF:    rd_view = {af, r.cpu_if[6:0]}; // R05
      `DXR_IX_MEM_CTL:   rd_view = r.mem_ctl;
      `DXR_IX_PAL_CTL:   rd_view = r.pal_ctl;
      `DXR_IX_PAGING:    rd_view = r.paging;
      `DXR_IX_START_TOP: rd_view = r.start_top;
      `DXR_IX_AUX_OFS:   rd_view = r.aux_ofs;
      `DXR_IX_TEXT_CTL:  rd_view = r.text_ctl;
      `DXR_IX_SWFLAGS2:  rd_view = r.swflags2; // R16
      `DXR_IX_LOW_MAP:   rd_view = r.low_map;
      `DXR_IX_HIGH_MAP:  rd_view = r.high_map;
      `DXR_IX_EMUL:      rd_view = {r.emul[7:4], mono, r.emul[1:0]}; // R19
      `DXR_IX_PROTECT:   rd_view = r.protect;
      default:           rd_view = `DXR_RST_ZERO;
    endcase
  endfunction : rd_view

  always_comb begin
    nxt_r        = r_ff;
    nxt_r.rvalid = 1'b0;
    nxt_r.acc    = dxr_pkg::DXR_ACC_IDLE;
    if (I_IDX_WR) begin
      nxt_r.index = I_WDATA[`DXR_IDX_W-1:0]; // R23
      nxt_r.acc   = dxr_pkg::DXR_ACC_WRITE;
    end else if (I_IDX_RD) begin
      nxt_r.rdata  = {1'b0, r_ff.index};
      nxt_r.rvalid = 1'b1;
      nxt_r.acc    = dxr_pkg::DXR_ACC_READ;
    end else if (I_DATA_RD) begin
      nxt_r.rdata  = rd_view(r_ff, I_ATTR_FF, mono_sync); // R23 R24
      nxt_r.rvalid = 1'b1;
      nxt_r.acc    = dxr_pkg::DXR_ACC_READ;
    end else if (I_DATA_WR) begin
      nxt_r.acc = dxr_pkg::DXR_ACC_WRITE;
      // these extension registers carry no protect group, so protect never blocks their writes
      case (r_ff.index)
        `DXR_IX_CPU_IF:    nxt_r.cpu_if    = wr_masked(r_ff.cpu_if, I_WDATA,
                                                       `DXR_CPU_IF_WMASK); // R01 R02 R03 R04
        `DXR_IX_MEM_CTL:   nxt_r.mem_ctl   = I_WDATA; // R06 R07 R08
        `DXR_IX_PAL_CTL:   nxt_r.pal_ctl   = I_WDATA; // R09 R10
        `DXR_IX_PAGING:    nxt_r.paging    = wr_masked(r_ff.paging, I_WDATA,
                                                       `DXR_PAGING_WMASK); // R11 R12
        `DXR_IX_START_TOP: nxt_r.start_top = wr_masked(r_ff.start_top, I_WDATA,
                                                       `DXR_START_WMASK); // R13
        `DXR_IX_AUX_OFS:   nxt_r.aux_ofs   = wr_masked(r_ff.aux_ofs, I_WDATA,
                                                       `DXR_AUX_WMASK); // R14
        `DXR_IX_TEXT_CTL:  nxt_r.text_ctl  = wr_masked(r_ff.text_ctl, I_WDATA,
                                                       `DXR_TEXT_WMASK); // R15
        `DXR_IX_SWFLAGS2:  nxt_r.swflags2  = I_WDATA; // R16
        `DXR_IX_LOW_MAP:   nxt_r.low_map   = I_WDATA; // R17
        `DXR_IX_HIGH_MAP:  nxt_r.high_map  = I_WDATA; // R18
        `DXR_IX_EMUL:      nxt_r.emul      = wr_masked(r_ff.emul, I_WDATA,
                                                       `DXR_EMUL_WMASK); // R19 R20 R21
        `DXR_IX_PROTECT:   nxt_r.protect   = wr_masked(r_ff.protect, I_WDATA,
                                                       `DXR_PROT_WMASK); // R22
        default:           nxt_r.acc       = dxr_pkg::DXR_ACC_IDLE;
      endcase
    end
  end

  always_comb begin
    nxt_shared = r_ff.cpu_if[1] ? irq_drv_o : I_PANEL_BIAS_EN; // R02
    // registered so the protect and hold outputs come straight from flops
    nxt_gprot  = {nxt_r.protect[6] | I_RETRACE_END_PROT, nxt_r.protect[5:0]}; // R22
    nxt_hold   = (nxt_r.cpu_if[4:3] == `DXR_ATTR_16BIT); // R03
    // group protect bit 5 gates the external palette strobes
    nxt_strobe = {~(I_EXT_PAL_RD && !r_ff.protect[5]),
                  ~(I_EXT_PAL_WR && !r_ff.protect[5])}; // R22
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      r_ff          <= '0;
      r_ff.mem_ctl  <= `DXR_RST_MEM_CTL;
      r_ff.pal_ctl  <= `DXR_RST_PAL_CTL;
      r_ff.acc      <= dxr_pkg::DXR_ACC_IDLE;
      strobe_ff     <= 2'b11;
      shared_ff     <= 1'b0;
      gprot_ff      <= '0;
      hold_ff       <= 1'b0;
    end else begin
      r_ff      <= nxt_r;
      strobe_ff <= nxt_strobe;
      shared_ff <= nxt_shared;
      gprot_ff  <= nxt_gprot;
      hold_ff   <= nxt_hold;
    end
  end

  assign O_RDATA           = r_ff.rdata;
  assign O_RVALID          = r_ff.rvalid;
  assign O_CPU_MEM_16BIT   = r_ff.cpu_if[0]; // R01
  assign O_SHARED_PIN      = shared_ff;
  assign O_ATTR_MAP        = r_ff.cpu_if[4:3]; // R03
  assign O_ATTR_FF_HOLD    = hold_ff; // R03
  assign O_IO_DECODE_10BIT = r_ff.cpu_if[5]; // R04
  assign O_ADDR_BIT16_EN   = r_ff.mem_ctl[2]; // R06
  assign O_STROBE_SCHEME   = r_ff.mem_ctl[4]; // R07
  assign O_WRITE_BUF_EN    = r_ff.mem_ctl[5]; // R08
  assign O_PAL_BYPASS      = r_ff.pal_ctl[5]; // R09
  assign O_GRAY_REDUCE     = r_ff.pal_ctl[7:6]; // R10
  assign O_EXT_MAP         = r_ff.paging[0]; // R11
  assign O_DUAL_MAP        = r_ff.paging[1]; // R11
  assign O_ADDR_DIV4       = r_ff.paging[2]; // R12
  assign O_LINEAR_ADDR     = r_ff.paging[4]; // R12
  assign O_START_MSB       = r_ff.start_top[0]; // R13
  assign O_OFFSET_LSB      = r_ff.aux_ofs[1:0]; // R14
  assign O_CURSOR_STEADY   = r_ff.text_ctl[2]; // R15
  assign O_CURSOR_XOR      = r_ff.text_ctl[3]; // R15
  assign O_LOW_MAP_BASE    = r_ff.low_map; // R17
  assign O_HIGH_MAP_BASE   = r_ff.high_map; // R18
  assign O_EMUL_MODE       = r_ff.emul[1:0]; // R19
  assign O_STATUS_SRC      = r_ff.emul[6:4]; // R20
  assign O_GROUP_PROTECT   = gprot_ff; // R22
  assign O_EXT_PAL_RD_N    = strobe_ff[1];
  assign O_EXT_PAL_WR_N    = strobe_ff[0];
  assign O_IRQ_O           = irq_drv_o;
  assign O_IRQ_OE          = irq_drv_oe;

  sequence s_idx_write(logic [6:0] ix);
    I_IDX_WR && I_WDATA[6:0] == ix;
  endsequence
  sequence s_data_write;
    I_DATA_WR && !I_IDX_WR && !I_IDX_RD && !I_DATA_RD;
  endsequence

  chk_index_load: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    I_IDX_WR |=> r_ff.index == $past(I_WDATA[6:0])) else $error("index not loaded"); // R23
  chk_flags_hold: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_idx_write(`DXR_IX_SWFLAGS2) ##1 s_data_write) |=> !O_RVALID
    && r_ff.swflags2 == $past(I_WDATA)) else $error("flags write lost"); // R16
  chk_index_read: assert property (@(posedge I_CLK) disable iff (!I_ARST_N) // R23
    (I_IDX_RD && !I_IDX_WR) |=> O_RVALID && O_RDATA == {1'b0, $past(r_ff.index)}
    && r_ff.acc == dxr_pkg::DXR_ACC_READ) else $error("index readback wrong");
  chk_retrace_or: assert property (@(posedge I_CLK) disable iff (!I_ARST_N) // R22
    I_RETRACE_END_PROT |=> O_GROUP_PROTECT[6]) else $error("group 0 protect not ored");
  chk_start_reserved: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    r_ff.start_top[7:1] == 7'h00) else $error("start top reserved bits set"); // R13
  chk_attr_ff_read: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (I_DATA_RD && !I_IDX_WR && !I_IDX_RD && r_ff.index == `DXR_IX_CPU_IF)
    |=> O_RVALID && O_RDATA[7] == $past(I_ATTR_FF)) else $error("attr ff status wrong"); // R05
  chk_emul_ro: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    r_ff.emul[3:2] == 2'b00) else $error("emulation readback bits written"); // R19
  chk_pal_gate: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    r_ff.protect[5] |=> O_EXT_PAL_RD_N && O_EXT_PAL_WR_N)
    else $error("palette strobe while protected"); // R22
  chk_shared_bias: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !r_ff.cpu_if[1] |=> O_SHARED_PIN == $past(I_PANEL_BIAS_EN))
    else $error("shared pin not bias enable"); // R02
  chk_read_keeps: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    I_DATA_RD && !I_IDX_WR |=> $stable(r_ff.protect) && $stable(r_ff.emul))
    else $error("read changed register"); // R24
endmodule : dxr_ext_regs
`default_nettype wire

// *** dxr_host.sv ***
`default_nettype none
module dxr_host (
  input  wire logic       i_clk,
  output logic            o_idx_wr,
  output logic            o_idx_rd,
  output logic            o_data_wr,
  output logic            o_data_rd,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_idx_wr  = 1'b0;
    o_idx_rd  = 1'b0;
    o_data_wr = 1'b0;
    o_data_rd = 1'b0;
    o_wdata   = 8'h5a;
  end
  // index write first, then data port write; bus shows inverted data once released
  task automatic put(input logic [6:0] idx, input logic [7:0] v);
    @(posedge i_clk);
    o_idx_wr  <= 1'b1;
    o_wdata   <= {1'b0, idx};
    @(posedge i_clk);
    o_idx_wr  <= 1'b0;
    o_data_wr <= 1'b1;
    o_wdata   <= v;
    @(posedge i_clk);
    o_data_wr <= 1'b0;
    o_wdata   <= ~v;
  endtask : put
  // answer must come exactly one cycle after the read strobe, else x is returned
  task automatic get(input logic [6:0] idx, input logic idx_port, output logic [7:0] d);
    int n;
    @(posedge i_clk);
    o_idx_wr  <= 1'b1;
    o_wdata   <= {1'b0, idx};
    @(posedge i_clk);
    o_idx_wr  <= 1'b0;
    o_wdata   <= ~{1'b0, idx};
    o_idx_rd  <= idx_port;
    o_data_rd <= ~idx_port;
    @(posedge i_clk);
    o_idx_rd  <= 1'b0;
    o_data_rd <= 1'b0;
    n = 0;
    #1;
    while (i_rvalid !== 1'b1 && n < 4) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    d = (n == 0 && i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask : get
endmodule : dxr_host
`default_nettype wire

// *** dxr_ext_regs_tb.sv ***
`include "dxr_map.svh"
`default_nettype none
module dxr_ext_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       arst_n, idx_wr, idx_rd, data_wr, data_rd, attr_ff, rprot, bias, irq_en;
  logic       irq_act, chbus, pal_rd, pal_wr, rvalid, m16, spin, ahold, dec10, b16, strb;
  logic       wbuf, pbyp, extm, dual, div4, lin, smsb, csty, cxor, prd_n, pwr_n, irq_o, irq_oe;
  logic [1:0] mono, amap, gray, olsb, emode;
  logic [2:0] ssrc;
  logic [6:0] gprot;
  logic [7:0] wdata, rdata, lmap, hmap, d;
  int         errors = 0;
  int         tests_run = 0;
  int         cycles = 0;
  logic [6:0] ix  [12] = '{`DXR_IX_CPU_IF, `DXR_IX_MEM_CTL, `DXR_IX_PAL_CTL, `DXR_IX_PAGING,
    `DXR_IX_START_TOP, `DXR_IX_AUX_OFS, `DXR_IX_TEXT_CTL, `DXR_IX_SWFLAGS2, `DXR_IX_LOW_MAP,
    `DXR_IX_HIGH_MAP, `DXR_IX_EMUL, `DXR_IX_PROTECT};
  logic [7:0] rst [12] = '{8'h00, 8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  logic [7:0] msk [12] = '{`DXR_CPU_IF_WMASK, 8'hff, 8'hff, `DXR_PAGING_WMASK, `DXR_START_WMASK,
    `DXR_AUX_WMASK, `DXR_TEXT_WMASK, 8'hff, 8'hff, 8'hff, `DXR_EMUL_WMASK, `DXR_PROT_WMASK};
  logic [7:0] pat [4]  = '{8'hff, 8'h55, 8'haa, 8'h00};

  always #2.5 clk = ~clk;

  dxr_host host_inst (.i_clk(clk), .o_idx_wr(idx_wr), .o_idx_rd(idx_rd), .o_data_wr(data_wr),
    .o_data_rd(data_rd), .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));

  dxr_ext_regs dxr_ext_regs_inst (.I_CLK(clk), .I_ARST_N(arst_n), .I_IDX_WR(idx_wr),
    .I_IDX_RD(idx_rd), .I_DATA_WR(data_wr), .I_DATA_RD(data_rd), .I_WDATA(wdata),
    .I_ATTR_FF(attr_ff), .I_MONO_CFG(mono), .I_RETRACE_END_PROT(rprot), .I_PANEL_BIAS_EN(bias),
    .I_IRQ_ENABLE(irq_en), .I_IRQ_ACTIVE(irq_act), .I_CHANNEL_BUS(chbus), .I_EXT_PAL_RD(pal_rd),
    .I_EXT_PAL_WR(pal_wr), .O_RDATA(rdata), .O_RVALID(rvalid), .O_CPU_MEM_16BIT(m16),
    .O_SHARED_PIN(spin), .O_ATTR_MAP(amap), .O_ATTR_FF_HOLD(ahold), .O_IO_DECODE_10BIT(dec10),
    .O_ADDR_BIT16_EN(b16), .O_STROBE_SCHEME(strb), .O_WRITE_BUF_EN(wbuf), .O_PAL_BYPASS(pbyp),
    .O_GRAY_REDUCE(gray), .O_EXT_MAP(extm), .O_DUAL_MAP(dual), .O_ADDR_DIV4(div4),
    .O_LINEAR_ADDR(lin), .O_START_MSB(smsb), .O_OFFSET_LSB(olsb), .O_CURSOR_STEADY(csty),
    .O_CURSOR_XOR(cxor), .O_LOW_MAP_BASE(lmap), .O_HIGH_MAP_BASE(hmap), .O_EMUL_MODE(emode),
    .O_STATUS_SRC(ssrc), .O_GROUP_PROTECT(gprot), .O_EXT_PAL_RD_N(prd_n),
    .O_EXT_PAL_WR_N(pwr_n), .O_IRQ_O(irq_o), .O_IRQ_OE(irq_oe));

  task automatic conclude;
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    host_inst.get(idx, 1'b0, got);
    chk(32'(got), 32'(exp));
  endtask : rd

  // covers the two-flop input path plus the output register
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      conclude;
    end
  end

  initial begin
    {arst_n, attr_ff, rprot, bias, irq_en, irq_act, chbus, pal_rd, pal_wr} = '0;
    mono = 2'b00;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 12; i++) rd(ix[i], rst[i]);
    foreach (pat[p]) begin
      for (int i = 0; i < 12; i++) host_inst.put(ix[i], pat[p]);
      for (int i = 0; i < 12; i++) rd(ix[i], pat[p] & msk[i]);
      if (pat[p] == 8'hff || pat[p] == 8'h00) begin
        chk(32'({m16, amap, dec10, b16, strb, wbuf, pbyp, gray, extm, dual, div4, lin, smsb,
          olsb, csty, cxor}), 32'({19{pat[p][0]}}));
        chk(32'({lmap, hmap, emode, ssrc, gprot}), 32'({28{pat[p][0]}}));
      end
    end
    @(posedge clk);
    attr_ff <= 1'b1;
    mono    <= 2'b10;
    settle;
    rd(`DXR_IX_CPU_IF, 8'h80);
    rd(`DXR_IX_EMUL, 8'h08);
    for (int m = 0; m < 3; m++) begin
      host_inst.put(`DXR_IX_CPU_IF, 8'(m << 3));
      settle;
      chk(32'({ahold, amap}), 32'({m == 1, 2'(m)}));
    end
    for (int m = 0; m < 4; m++) begin
      host_inst.put(`DXR_IX_PAL_CTL, {2'(m), 6'h10});
      host_inst.put(`DXR_IX_EMUL, {6'h00, 2'(m)});
      settle;
      chk(32'({gray, emode}), 32'({2'(m), 2'(m)}));
    end
    host_inst.put(7'h20, 8'hff);
    rd(7'h20, 8'h00);
    host_inst.get(7'h20, 1'b1, d);
    chk(32'(d), 32'h20);
    @(posedge clk);
    pal_rd <= 1'b1;
    pal_wr <= 1'b1;
    host_inst.put(`DXR_IX_PROTECT, 8'h7f);
    settle;
    chk(32'({prd_n, pwr_n, gprot}), 32'({2'b11, 7'h7f}));
    host_inst.put(`DXR_IX_SWFLAGS2, 8'ha5);
    rd(`DXR_IX_SWFLAGS2, 8'ha5);
    host_inst.put(`DXR_IX_PROTECT, 8'h00);
    rprot <= 1'b1;
    settle;
    chk(32'({prd_n, pwr_n, gprot}), 32'({2'b00, 7'h40}));
    host_inst.put(`DXR_IX_CPU_IF, 8'h00);
    bias   <= 1'b1;
    irq_en <= 1'b1;
    settle;
    chk(32'(spin), 32'h1);
    host_inst.put(`DXR_IX_CPU_IF, 8'h02);
    bias <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      host_inst.put(`DXR_IX_EMUL, {k[2], 7'h00});
      {chbus, irq_act} <= 2'(k);
      settle;
      // shared pin carries the irq pin level once routed
      chk(32'({spin, irq_oe, irq_oe & irq_o}),
          32'({k[2] & k[0], k[2] | (k[1] & k[0]), k[2] & k[0]}));
    end
    @(posedge clk);
    irq_en <= 1'b0;
    settle;
    chk(32'(irq_oe), 32'h0);
    conclude;
  end
endmodule : dxr_ext_regs_tb
`default_nettype wire
